// >>> hw/rcp_if.sv
`timescale 1ns/10ps
interface rcp_tmr_if;
    import rcp_pkg::*;
    logic start;
    logic [TMR_W-1:0] load;
    logic busy;
    modport tmr_mp(input start, input load, output busy);
    modport user_mp(output start, output load, input busy);
endinterface

interface rcp_sync_if;
    import rcp_pkg::*;
    logic [SYNC_W-1:0] raw;
    logic [SYNC_W-1:0] clean;
    modport sync_mp(input raw, output clean);
    modport user_mp(output raw, input clean);
endinterface

// >>> hw/rcp_pin_interface.sv
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/10ps
module rcp_pin_interface
    import rcp_pkg::*;
#(
    parameter int ACK_HOLD = ACK_HOLD_CYCLES,
    parameter int TX_PERIOD = TX_PERIOD_CYCLES,
    parameter int FACTORY_GAP = FACTORY_GAP_CYCLES
)
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic [7:0] status_lines_i,
    output logic [7:0] status_lines_o,
    output logic [7:0] status_lines_oe_o,
    output logic [7:0] status_lines_pd_o,
    output logic bonding_pd_o,
    input wire logic low_group_dir_select_i,
    input wire logic high_group_dir_select_i,
    input wire logic low_power_req_n_i,
    input wire logic toggle_select_i,
    input wire logic ack_enable_i,
    input wire logic bonding_req_i,
    input wire logic cmd_data_in_i,
    output logic cmd_data_out_o,
    output logic cmd_rx_o,
    input wire logic cmd_tx_i,
    output logic rx_amp_enable_o,
    output logic tx_amp_enable_o,
    output logic activity_indicator_o,
    output logic reply_received_o,
    input wire logic modem_rx_active_i,
    input wire logic modem_tx_active_i,
    input wire logic rx_cmd_valid_i,
    input wire logic [7:0] rx_cmd_state_i,
    input wire logic rx_same_src_i,
    input wire logic rx_missed_i,
    input wire logic rx_ack_i,
    output logic tx_req_o,
    output logic [7:0] tx_state_o,
    output logic ack_send_o,
    output logic pairing_start_o,
    output logic factory_default_o,
    output logic low_power_o,
    output logic link_up_o,
    output logic initiating_unit_o,
    output logic responding_unit_o,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o
);
    typedef struct packed {
        logic [7:0] out_lines;
        logic [7:0] last_rx;
        logic link_up;
        logic [3:0] miss_cnt;
        rcp_tx_state_t tx_st;
        logic [TX_CNT_W-1:0] tx_cnt;
        logic tx_req;
        logic [7:0] tx_state;
        logic sent;
        logic ack_send;
        logic pair_prev;
        logic pair_start;
        logic [2:0] edge_cnt;
        logic factory;
        logic [21:0] flash;
        logic [7:0] ctrl;
        logic [7:0] rdata;
        logic rx_amp;
        logic tx_amp;
        logic ind;
        logic cmd_out;
    } rcp_top_state_t;

    rcp_top_state_t s_reg;
    rcp_top_state_t s_next;

    rcp_sync_if sync_if();
    rcp_tmr_if ack_tmr();
    rcp_tmr_if gap_tmr();

    logic [7:0] lines_clean;
    logic [7:0] in_mask;
    logic [7:0] out_mask;
    logic [7:0] line_states;
    logic [7:0] rx_rise;
    logic pwr_n;
    logic awake;
    logic all_in;
    logic all_out;
    logic any_in;
    logic accept;
    logic pair_rise;
    logic sw_pair;

    function automatic logic is_reg(input logic [7:0] a, input logic [7:0] off);
        is_reg = (a == off);
    endfunction

    // ****************************************************************
    // Input synchronisation and submodules
    // ****************************************************************
    assign sync_if.raw = {cmd_data_in_i, bonding_req_i, ack_enable_i, toggle_select_i,
                          low_power_req_n_i, high_group_dir_select_i, low_group_dir_select_i,
                          status_lines_i};

    rcp_sync u_sync (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .ce_i(ce_i),
        .sy(sync_if.sync_mp)
    );

    rcp_timer u_ack_tmr (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .ce_i(ce_i),
        .t(ack_tmr.tmr_mp)
    );

    rcp_timer u_gap_tmr (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .ce_i(ce_i),
        .t(gap_tmr.tmr_mp)
    );

    // ****************************************************************
    // Direction, role and activity decode
    // ****************************************************************
    assign lines_clean = sync_if.clean[SB_LINES +: 8];
    assign in_mask = {{4{sync_if.clean[SB_DIR_HI]}}, {4{sync_if.clean[SB_DIR_LO]}}};
    assign out_mask = ~in_mask;
    assign pwr_n = sync_if.clean[SB_PWR_N];
    assign awake = pwr_n & s_reg.ctrl[CTRL_RADIO_EN];
    assign all_in = &in_mask;
    assign all_out = ~|in_mask;
    assign any_in = |(lines_clean & in_mask);
    assign line_states = (lines_clean & in_mask) | (s_reg.out_lines & out_mask);
    assign accept = awake & !all_in & rx_cmd_valid_i & (!s_reg.link_up | rx_same_src_i);
    assign rx_rise = rx_cmd_state_i & ~s_reg.last_rx;
    assign pair_rise = sync_if.clean[SB_PAIR] & !s_reg.pair_prev;
    assign sw_pair = reg_wr_i & is_reg(reg_addr_i, REG_CTRL) & reg_wdata_i[CTRL_PAIR];

    assign ack_tmr.start = awake & rx_ack_i & s_reg.sent & !all_out;
    assign ack_tmr.load = TMR_W'(ACK_HOLD);
    assign gap_tmr.start = awake & pair_rise;
    assign gap_tmr.load = TMR_W'(FACTORY_GAP);

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb
    begin
        s_next = s_reg;
        s_next.tx_req = 1'h0;
        s_next.ack_send = 1'h0;
        s_next.pair_start = 1'h0;
        s_next.factory = 1'h0;
        s_next.rdata = 8'h00;
        s_next.flash = s_reg.flash + 22'h1;
        s_next.pair_prev = sync_if.clean[SB_PAIR];
        if (!awake)
        begin
            s_next.out_lines = 8'h00;
            s_next.last_rx = 8'h00;
            s_next.link_up = 1'h0;
            s_next.miss_cnt = 4'h0;
            s_next.tx_st = TX_IDLE;
            s_next.tx_cnt = '0;
            s_next.sent = 1'h0;
            s_next.edge_cnt = 3'h0;
        end
        else
        begin
            if (accept)
            begin
                s_next.link_up = 1'h1;
                s_next.miss_cnt = 4'h0;
                s_next.last_rx = rx_cmd_state_i;
                s_next.ack_send = sync_if.clean[SB_ACK_EN];
                if (sync_if.clean[SB_TOGGLE])
                begin
                    s_next.out_lines = s_reg.out_lines ^ rx_rise;
                end
                else
                begin
                    s_next.out_lines = rx_cmd_state_i;
                end
            end
            else if (rx_missed_i && s_reg.link_up)
            begin
                if (s_reg.miss_cnt == LINK_MISS_LIMIT - 4'h1)
                begin
                    s_next.link_up = 1'h0;
                    s_next.miss_cnt = 4'h0;
                    s_next.last_rx = 8'h00;
                    if (!sync_if.clean[SB_TOGGLE])
                    begin
                        s_next.out_lines = 8'h00;
                    end
                end
                else
                begin
                    s_next.miss_cnt = s_reg.miss_cnt + 4'h1;
                end
            end
            s_next.out_lines = s_next.out_lines & out_mask;
            case (s_reg.tx_st)
                TX_IDLE:
                begin
                    s_next.sent = 1'h0;
                    if (any_in && !all_out)
                    begin
                        s_next.tx_req = 1'h1;
                        s_next.tx_state = line_states;
                        s_next.tx_cnt = TX_CNT_W'(TX_PERIOD - 1);
                        s_next.tx_st = TX_ACTIVE;
                        s_next.sent = 1'h1;
                    end
                end
                TX_ACTIVE, TX_FINAL:
                begin
                    if (s_reg.tx_cnt != '0)
                    begin
                        s_next.tx_cnt = s_reg.tx_cnt - 19'h1;
                    end
                    else if (any_in || s_reg.tx_st == TX_ACTIVE)
                    begin
                        s_next.tx_req = 1'h1;
                        s_next.tx_state = line_states;
                        s_next.tx_cnt = TX_CNT_W'(TX_PERIOD - 1);
                        s_next.tx_st = any_in ? TX_ACTIVE : TX_FINAL;
                    end
                    else
                    begin
                        s_next.tx_st = TX_IDLE;
                    end
                end
                default:
                begin
                    s_next.tx_st = TX_IDLE;
                end
            endcase
            if (pair_rise)
            begin
                if (!gap_tmr.busy)
                begin
                    s_next.edge_cnt = 3'h1;
                end
                else if (s_reg.edge_cnt == FACTORY_EDGES - 3'h1)
                begin
                    s_next.factory = 1'h1;
                    s_next.edge_cnt = 3'h0;
                end
                else
                begin
                    s_next.edge_cnt = s_reg.edge_cnt + 3'h1;
                end
            end
            s_next.pair_start = pair_rise | sw_pair;
        end
        s_next.rx_amp = awake & !all_in & modem_rx_active_i;
        s_next.tx_amp = awake & modem_tx_active_i;
        s_next.ind = awake & ((s_reg.tx_st != TX_IDLE) | s_reg.link_up
                     | (gap_tmr.busy & s_reg.flash[FLASH_BIT]));
        s_next.cmd_out = awake ? cmd_tx_i : 1'h1;
        if (reg_wr_i && is_reg(reg_addr_i, REG_CTRL))
        begin
            s_next.ctrl = reg_wdata_i & ~(8'h01 << CTRL_PAIR);
        end
        if (reg_rd_i)
        begin
            if (is_reg(reg_addr_i, REG_CTRL))
            begin
                s_next.rdata = s_reg.ctrl;
            end
            else if (is_reg(reg_addr_i, REG_STATUS))
            begin
                s_next.rdata = {!pwr_n, ack_tmr.busy, s_reg.link_up, s_reg.tx_st != TX_IDLE,
                                !all_out, !all_in, sync_if.clean[SB_TOGGLE], sync_if.clean[SB_ACK_EN]};
            end
            else if (is_reg(reg_addr_i, REG_LINES))
            begin
                s_next.rdata = line_states;
            end
            else
            begin
                s_next.rdata = 8'h00;
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            s_reg <= '0;
            s_reg.ctrl <= CTRL_RST;
            s_reg.cmd_out <= 1'h1;
        end
        else if (ce_i)
        begin
            s_reg <= s_next;
        end
    end

    // ****************************************************************
    // Pins and outputs
    // ****************************************************************
    generate
        for (genvar i = 0; i < 8; i++)
        begin : g_line
            assign status_lines_o[i] = s_reg.out_lines[i];
            assign status_lines_oe_o[i] = awake & out_mask[i];
            assign status_lines_pd_o[i] = 1'h1;
        end
    endgenerate

    assign bonding_pd_o = 1'h1;
    assign cmd_data_out_o = s_reg.cmd_out;
    assign cmd_rx_o = sync_if.clean[SB_CMD];
    assign rx_amp_enable_o = s_reg.rx_amp;
    assign tx_amp_enable_o = s_reg.tx_amp;
    assign activity_indicator_o = s_reg.ind;
    assign reply_received_o = ack_tmr.busy;
    assign tx_req_o = s_reg.tx_req;
    assign tx_state_o = s_reg.tx_state;
    assign ack_send_o = s_reg.ack_send;
    assign pairing_start_o = s_reg.pair_start;
    assign factory_default_o = s_reg.factory;
    assign low_power_o = !pwr_n;
    assign link_up_o = s_reg.link_up;
    assign initiating_unit_o = !all_out;
    assign responding_unit_o = !all_in;
    assign reg_rdata_o = s_reg.rdata;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);

    chk_dir_low_grp: assert property (!sync_if.clean[SB_DIR_LO] && awake |-> status_lines_oe_o[3:0] == 4'hF)
        else $error("low group not driven as outputs");
    chk_dir_high_grp: assert property (sync_if.clean[SB_DIR_HI] |-> status_lines_oe_o[7:4] == 4'h0)
        else $error("high group driven while inputs");
    chk_power_down: assert property (ce_i && !pwr_n |=> status_lines_o == 8'h00 && !tx_amp_enable_o)
        else $error("activity during power down");
    chk_toggle_line: assert property (ce_i && accept && sync_if.clean[SB_TOGGLE] && rx_rise[0] && out_mask[0]
        |=> status_lines_o[0] != $past(status_lines_o[0]))
        else $error("toggle did not invert line");
    chk_momentary_follow: assert property (ce_i && accept && !sync_if.clean[SB_TOGGLE]
        |=> s_reg.out_lines == ($past(rx_cmd_state_i) & $past(out_mask)))
        else $error("momentary output not following");
    chk_ack_send: assert property (ce_i && accept |=> ack_send_o == $past(sync_if.clean[SB_ACK_EN]))
        else $error("acknowledge send mismatch");
    chk_pair_start: assert property (ce_i && awake && pair_rise |=> pairing_start_o)
        else $error("pairing not started");
    chk_reply_hold: assert property (ce_i && ack_tmr.start |=> reply_received_o [*4])
        else $error("reply output not held");
    chk_link_drop: assert property (ce_i && awake && !accept && rx_missed_i && s_reg.link_up
        && s_reg.miss_cnt == 4'h7 |=> !link_up_o)
        else $error("link not dropped after eight misses");
    chk_tx_spacing: assert property (ce_i && tx_req_o && awake |=> !tx_req_o [*8])
        else $error("control messages too close");
    chk_rx_amp_iu: assert property (ce_i && all_in |=> !rx_amp_enable_o)
        else $error("receive amplifier on while initiating only");

    cov_toggle: cover property (accept && sync_if.clean[SB_TOGGLE] && |rx_rise);
    cov_reply: cover property (ack_tmr.start);
    cov_factory: cover property (s_reg.factory);
    cov_link_drop: cover property (s_reg.link_up ##1 !s_reg.link_up);
endmodule

// >>> hw/rcp_pkg.sv
package rcp_pkg;
    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 50;
    localparam int ACK_HOLD_MS = 100;
    localparam int ACK_HOLD_CYCLES = ACK_HOLD_MS * 1000000 / CLK_PERIOD_NS;
    localparam real TX_PERIOD_MS = 13.33;
    localparam int TX_PERIOD_CYCLES = int'(TX_PERIOD_MS * 1.0e6 / CLK_PERIOD_NS);
    localparam int FACTORY_GAP_MS = 1000;
    localparam int FACTORY_GAP_CYCLES = FACTORY_GAP_MS * 1000000 / CLK_PERIOD_NS;
    localparam int TX_CNT_W = 19;
    localparam int TMR_W = 32;
    localparam int FLASH_BIT = 21;
    localparam logic [3:0] LINK_MISS_LIMIT = 4'h8;
    localparam logic [2:0] FACTORY_EDGES = 3'h4;

    // ****************************************************************
    // Synchroniser bit positions
    // ****************************************************************
    localparam int SB_LINES = 0;
    localparam int SB_DIR_LO = 8;
    localparam int SB_DIR_HI = 9;
    localparam int SB_PWR_N = 10;
    localparam int SB_TOGGLE = 11;
    localparam int SB_ACK_EN = 12;
    localparam int SB_PAIR = 13;
    localparam int SB_CMD = 14;
    localparam int SYNC_W = 15;
    localparam logic [SYNC_W-1:0] SYNC_RST = 15'h0400;

    // ****************************************************************
    // Registers
    // ****************************************************************
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_LINES = 8'h08;
    localparam logic [7:0] CTRL_RST = 8'h01;
    localparam int CTRL_RADIO_EN = 0;
    localparam int CTRL_PAIR = 1;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_ACTIVE = 2'b01,
        TX_FINAL = 2'b10
    } rcp_tx_state_t;
endpackage

// >>> hw/rcp_sync.sv
`timescale 1ns/10ps
module rcp_sync
    import rcp_pkg::*;
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    rcp_sync_if.sync_mp sy
);
    typedef struct packed {
        logic [SYNC_W-1:0] s1;
        logic [SYNC_W-1:0] s2;
        logic [SYNC_W-1:0] s3;
        logic [SYNC_W-1:0] q;
    } rcp_sync_state_t;

    rcp_sync_state_t s_reg;
    rcp_sync_state_t s_next;

    // ****************************************************************
    // Three stages, change taken when stages two and three agree
    // ****************************************************************
    always_comb
    begin
        s_next = s_reg;
        s_next.s1 = sy.raw;
        s_next.s2 = s_reg.s1;
        s_next.s3 = s_reg.s2;
        s_next.q = (s_reg.s2 & s_reg.s3) | (s_reg.q & (s_reg.s2 | s_reg.s3));
    end

    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            s_reg <= {4{SYNC_RST}};
        end
        else if (ce_i)
        begin
            s_reg <= s_next;
        end
    end

    assign sy.clean = s_reg.q;

    chk_sync_agree: assert property (@(posedge clk_i) disable iff (!resetn_i)
        ce_i && (s_reg.s2 == s_reg.s3) |=> (s_reg.q == $past(s_reg.s3)))
        else $error("synchroniser output missed an agreed change");
endmodule

// >>> hw/rcp_timer.sv
`timescale 1ns/10ps
module rcp_timer
    import rcp_pkg::*;
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    rcp_tmr_if.tmr_mp t
);
    typedef struct packed {
        logic [TMR_W-1:0] cnt;
    } rcp_timer_state_t;

    rcp_timer_state_t s_reg;
    rcp_timer_state_t s_next;

    // ****************************************************************
    // Restartable countdown
    // ****************************************************************
    always_comb
    begin
        s_next = s_reg;
        if (t.start)
        begin
            s_next.cnt = t.load;
        end
        else if (s_reg.cnt != '0)
        begin
            s_next.cnt = s_reg.cnt - 32'h1;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            s_reg <= '0;
        end
        else if (ce_i)
        begin
            s_reg <= s_next;
        end
    end

    assign t.busy = (s_reg.cnt != '0);

    chk_timer_restart: assert property (@(posedge clk_i) disable iff (!resetn_i)
        ce_i && t.start |=> (s_reg.cnt == $past(t.load)))
        else $error("timer did not restart on start");
endmodule

// >>> testbench/rcp_far_side.sv
`timescale 1ns/10ps
// ****
// Buttons and pull-downs on the status lines
// ****
module rcp_far_side
(
    input wire logic [7:0] oe_i,
    input wire logic [7:0] dev_i,
    input wire logic [7:0] pd_i,
    input wire logic [7:0] btn_en_i,
    input wire logic [7:0] btn_i,
    output logic [7:0] line_o
);
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            if (oe_i[i])
                line_o[i] = dev_i[i];
            else if (btn_en_i[i])
                line_o[i] = btn_i[i];
            else
                line_o[i] = pd_i[i] ? 1'b0 : ~dev_i[i];
        end
    end
endmodule

// >>> testbench/rcp_pin_interface_tb.sv
`timescale 1ns/10ps
module rcp_pin_interface_tb;
    import rcp_pkg::*;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic lo_d = 1'b0, hi_d = 1'b1, pwr_n = 1'b1, tgl = 1'b0, ack_en = 1'b1, bond = 1'b0, cmd_in = 1'b0;
    logic cmd_tx = 1'b1, mrx = 1'b0, mtx = 1'b0, vld = 1'b0, miss = 1'b0, ack = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [7:0] st = 8'h00, addr = 8'h00, wdat = 8'h00, btn = 8'h00, rnd = 8'h5B, exp_o = 8'h00, last = 8'h00, rq;
    logic ps, fs, ce = 1'b1, same = 1'b1;
    wire logic [7:0] line, dout, oe, pd, rdata, txs;
    wire logic bpd, cout, crx, rxa, txa, ind, rep, treq, asend, pstart, fdef, lp, lnk, iu, ru;
    int fails = 0, tests_run = 0, n;
    always #25 clk_i = ~clk_i;
    // ****
    // Device and far side
    // ****
    rcp_pin_interface #(.ACK_HOLD(20), .TX_PERIOD(10), .FACTORY_GAP(50)) rcp_pin_interface_inst (
        .clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce), .status_lines_i(line), .status_lines_o(dout),
        .status_lines_oe_o(oe), .status_lines_pd_o(pd), .bonding_pd_o(bpd), .low_group_dir_select_i(lo_d),
        .high_group_dir_select_i(hi_d), .low_power_req_n_i(pwr_n), .toggle_select_i(tgl), .ack_enable_i(ack_en),
        .bonding_req_i(bond), .cmd_data_in_i(cmd_in), .cmd_data_out_o(cout), .cmd_rx_o(crx), .cmd_tx_i(cmd_tx),
        .rx_amp_enable_o(rxa), .tx_amp_enable_o(txa), .activity_indicator_o(ind), .reply_received_o(rep),
        .modem_rx_active_i(mrx), .modem_tx_active_i(mtx), .rx_cmd_valid_i(vld), .rx_cmd_state_i(st),
        .rx_same_src_i(same), .rx_missed_i(miss), .rx_ack_i(ack), .tx_req_o(treq), .tx_state_o(txs),
        .ack_send_o(asend), .pairing_start_o(pstart), .factory_default_o(fdef), .low_power_o(lp),
        .link_up_o(lnk), .initiating_unit_o(iu), .responding_unit_o(ru), .reg_addr_i(addr),
        .reg_wdata_i(wdat), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata));
    rcp_far_side rcp_far_side_inst (.oe_i(oe), .dev_i(dout), .pd_i(pd), .btn_en_i(8'hF0), .btn_i(btn),
        .line_o(line));
    // ****
    // Helpers
    // ****
    task automatic cy(input int k);
        repeat (k) @(posedge clk_i);
        #1;
    endtask
    task automatic ck(input logic ok, input string m);
        tests_run++;
        if (ok !== 1'b1)
        begin
            fails++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask
    function automatic logic [7:0] nx(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic logic [7:0] f_out(input logic [7:0] o, s, p, m, input logic t);
        return t ? o ^ (s & ~p & m) : s & m;
    endfunction
    task automatic rxp(input logic [7:0] s);
        vld <= 1'b1;
        st <= s;
        cy(1);
        vld <= 1'b0;
        exp_o = f_out(exp_o, s, last, {{4{~hi_d}}, {4{~lo_d}}}, tgl);
        last = s;
        ck(dout === exp_o, "line drive");
        ck(asend === ack_en, "ack send");
        cy(1);
    endtask
    task automatic reg_acc(input logic [7:0] a, input logic w, input logic [7:0] v, output logic [7:0] q);
        addr <= a;
        wdat <= v;
        wr <= w;
        rd <= ~w;
        cy(1);
        wr <= 1'b0;
        rd <= 1'b0;
        q = rdata;
        cy(1);
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // ****
    // Tests
    // ****
    initial
    begin
        #500000;
        fails++;
        final_report;
    end
    initial
    begin
        cy(16);
        ck(pd === 8'hFF && bpd === 1'b1 && cout === 1'b1, "reset levels");
        resetn_i <= 1'b1;
        for (int d = 0; d < 4; d++)
        begin
            lo_d <= d[0];
            hi_d <= d[1];
            cy(6);
            ck(oe === {{4{~d[1]}}, {4{~d[0]}}}, "direction");
            if (d == 0 || d == 3)
                ck(iu === d[0] && ru === ~d[0], "unit role");
        end
        lo_d <= 1'b0;
        hi_d <= 1'b1;
        cmd_in <= 1'b1;
        cmd_tx <= 1'b0;
        mrx <= 1'b1;
        mtx <= 1'b1;
        cy(6);
        ck(crx === 1'b1 && cout === 1'b0, "serial lines");
        ck(rxa === 1'b1 && txa === 1'b1, "amp on");
        mrx <= 1'b0;
        mtx <= 1'b0;
        cy(2);
        ck(rxa === 1'b0 && txa === 1'b0, "amp off");
        $display("done: pins");
        for (int i = 0; i < 8; i++)
        begin
            rnd = nx(rnd);
            ack_en <= rnd[0];
            cy(6);
            rxp(rnd);
        end
        ck(lnk === 1'b1 && ind === 1'b1, "link up");
        tgl <= 1'b1;
        cy(6);
        rxp(8'h00);
        for (int i = 0; i < 6; i++)
        begin
            rnd = nx(rnd);
            rxp(rnd);
        end
        tgl <= 1'b0;
        miss <= 1'b1;
        cy(7);
        ck(lnk === 1'b1, "seven misses");
        cy(1);
        miss <= 1'b0;
        ck(lnk === 1'b0 && dout === 8'h00, "link drop");
        $display("done: receive");
        reg_acc(REG_STATUS, 1'b0, 8'h00, rq);
        ck(rq[7:5] === 3'h0 && rq[1:0] === {1'b0, ack_en}, "status read");
        reg_acc(8'h0C, 1'b0, 8'h00, rq);
        ck(rq === 8'h00, "unmapped read");
        reg_acc(REG_CTRL, 1'b1, 8'h00, rq);
        cy(1);
        ck(oe === 8'h00, "radio off");
        reg_acc(REG_CTRL, 1'b1, 8'h03, rq);
        reg_acc(REG_CTRL, 1'b0, 8'h00, rq);
        ck(rq === 8'h01, "control readback");
        btn <= 8'h10;
        n = 0;
        do
        begin
            cy(1);
            n++;
        end while (treq !== 1'b1 && n < 20);
        ck(treq === 1'b1 && txs[4] === 1'b1, "send state");
        n = 0;
        do
        begin
            cy(1);
            n++;
        end while (treq !== 1'b1 && n < 30);
        ck(n === 10, "send period");
        ack <= 1'b1;
        cy(1);
        ack <= 1'b0;
        n = 0;
        while (rep === 1'b1 && n < 40)
        begin
            cy(1);
            n++;
        end
        ck(n === 20, "reply hold");
        btn <= 8'h00;
        $display("done: transmit");
        for (int i = 0; i < 4; i++)
        begin
            bond <= 1'b1;
            ps = 1'b0;
            fs = 1'b0;
            repeat (8)
            begin
                cy(1);
                ps = ps | pstart;
                fs = fs | fdef;
            end
            ck(ps === 1'b1, "pair start");
            ck(fs === (i == 3), "factory default");
            bond <= 1'b0;
            cy(6);
        end
        pwr_n <= 1'b0;
        cy(6);
        ck(lp === 1'b1 && oe === 8'h00, "power down");
        pwr_n <= 1'b1;
        cy(6);
        ck(lp === 1'b0, "power up");
        rxp(8'h0F);
        same <= 1'b0;
        vld <= 1'b1;
        st <= 8'h00;
        cy(1);
        vld <= 1'b0;
        same <= 1'b1;
        ck(dout === 8'h0F && asend === 1'b0, "foreign source ignored");
        cy(1);
        ce <= 1'b0;
        vld <= 1'b1;
        cy(2);
        vld <= 1'b0;
        ck(dout === 8'h0F && lnk === 1'b1, "clock enable freeze");
        ce <= 1'b1;
        cy(1);
        resetn_i <= 1'b0;
        cy(2);
        ck(dout === 8'h00 && lnk === 1'b0 && cout === 1'b1, "mid reset");
        resetn_i <= 1'b1;
        cy(2);
        ck(dout === 8'h00 && lnk === 1'b0 && cout === 1'b0, "after reset");
        $display("done: modes");
        final_report;
    end
endmodule
